// File: common/sdmc_pkg.sv
package sdmc_pkg;

  // ******************************************************
  // SFR map
  // ******************************************************
  localparam logic [7:0] SDMC_PCFG_ADDR  = 8'hD2; // primary_converter_config
  localparam logic [7:0] SDMC_EXC_ADDR   = 8'hD5; // excitation_source_control
  localparam logic [7:0] SDMC_MODE_ADDR  = 8'hD1; // converter_mode_register
  localparam logic [7:0] SDMC_AUX1_ADDR  = 8'hD3; // aux_config_one
  localparam logic [7:0] SDMC_AUX2_ADDR  = 8'hD4; // aux_config_two
  localparam logic [7:0] SDMC_STAT_ADDR  = 8'hD8; // converter_status_register
  localparam logic [7:0] SDMC_PROCESSOR_POWER_CONTROL_ADDR  = 8'h87; // processor_power_control

  // ******************************************************
  // Reset values and field layout
  // ******************************************************
  localparam logic [7:0] SDMC_PCFG_RST   = 8'h07;
  localparam logic [7:0] SDMC_EXC_RST    = 8'h00;
  localparam logic [7:0] SDMC_MODE_RST   = 8'h00;
  localparam logic [7:0] SDMC_PCFG_MASK  = 8'hE7; // Bits 4:3 unimplemented
  localparam logic [7:0] SDMC_EXC_MASK   = 8'h4F; // Bits 7,5,4 unimplemented
  localparam int         SDMC_MD_LSB     = 0;     // Mode bits 2:0
  localparam int         SDMC_P_EN_BIT   = 5;     // primary_enable
  localparam int         SDMC_A_EN_BIT   = 4;     // aux_enable
  localparam int         SDMC_CHOP_BIT   = 3;     // Chop disable when set
  localparam int         SDMC_PD_BIT     = 1;     // processor_power_down_bit
  localparam int         SDMC_TSENS_BIT  = 7;     // Aux temp sensor select in aux_config_one
  localparam logic [2:0] SDMC_MD_PDOWN   = 3'h0;
  localparam logic [2:0] SDMC_MD_CAL_LO  = 3'h4;  // Codes 4..7 are calibrations
  localparam logic [1:0] SDMC_BUF_ON     = 2'h0;
  localparam logic [1:0] SDMC_BUF_BYP    = 2'h2;
  localparam logic [2:0] SDMC_CAL_CHOP   = 3'h2;  // Outputs per calibration, chop on
  localparam logic [2:0] SDMC_CAL_NOCHOP = 3'h4;  // Outputs per calibration, chop off
  localparam logic [1:0] SDMC_AUX_SYNC   = 2'h3;  // Max primary outputs aux waits

  // Power-up wait: figure in microseconds, derived cycles at 200 MHz
  localparam int SDMC_PWRUP_US  = 500;
  localparam int SDMC_CLK_MHZ   = 200;
  localparam int SDMC_PWRUP_CYC = SDMC_PWRUP_US * SDMC_CLK_MHZ;

  // ******************************************************
  // Types
  // ******************************************************
  typedef struct packed {
    logic [1:0] buf_sel;   // input_buffer_select
    logic       unipolar;  // unipolar_select
    logic [2:0] range_sel; // input_range_select
  } sdmc_front_t;

  typedef struct packed {
    logic       burnout_en;
    logic       src_a_en;
    logic       src_b_en;
    logic       src_a_analog_input_eight;
    logic       src_b_analog_input_seven;
  } sdmc_exc_t;

  typedef enum logic [3:0] {
    SDMC_IDLE = 4'b0001,
    SDMC_PWUP = 4'b0010,
    SDMC_RUN  = 4'b0100,
    SDMC_CAL  = 4'b1000
  } sdmc_state_t;

endpackage

// File: src/sdmc_ctrl.sv
`timescale 1ns/1ps

// Operation
// - Any change of mode bits resets both converters at once.
// - Rewriting the mode bits with same value also resets both converters.
// - Aux config writes with primary enabled, or primary enable rising, reset both.
// - Aux config write with primary disabled resets only auxiliary converter; aux enable rising is a mode write and resets both.
// - After aux-only reset, aux aligns to primary outputs, up to three.
// - Aux config write after primary finished lets aux start at once.
// - Power-down keeps mode register; resume restarts selected operation.
// - Writing a calibration mode clears ready flags and starts calibration.
// - Calibration end writes cal regs, sets flags, clears mode bits to 000.
// - Aux calibration with temp sensor sets aux ready and error, no cal write.
// - Calibration lasts two outputs with chop, four without.
// - Buffer field 00 buffers, 10 bypasses; 01 and 11 reserved.
// - Bit 5 selects unipolar coding when set, bipolar when clear.
// - Range field selects 20 mV span at 000 doubling to 2.56 V at 111.
// - Primary config bits 4 and 3 unimplemented; writes ignored.
// - Low four excitation bits enable and route both current sources.
// - Bit0 enables A, bit1 B, bit2 routes A, bit3 routes B.
// - Bit 6 enables burnout sources on primary pairs only.
// - Excitation writes act immediately and reset no converter.
module sdmc_ctrl #(
  parameter int PWRUP_CYC = sdmc_pkg::SDMC_PWRUP_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               sfr_wr,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic [7:0]         sfr_wdata,
  input  wire logic               prim_out_tick,
  input  wire logic               aux_out_tick,
  output logic [7:0]              sfr_rdata,
  output logic                    prim_reset,
  output logic                    aux_reset,
  output logic                    aux_start,
  output logic                    cal_write,
  output sdmc_pkg::sdmc_front_t   front_cfg,
  output sdmc_pkg::sdmc_exc_t     exc_cfg,
  output logic                    conv_powered
);
  import sdmc_pkg::*;

  logic [7:0]  mode_r;
  logic [7:0]  aux1_r;
  logic [7:0]  aux2_r;
  logic [7:0]  pcfg_r;
  logic [7:0]  exc_r;
  logic        pd_r;
  logic        primary_ready_flag_r;
  logic        aux_ready_flag_r;
  logic        aux_error_flag_r;
  logic        aux_wait_r;
  logic [1:0]  aux_cnt_r;
  logic [2:0]  cal_cnt_r;
  logic        cal_aux_r;
  logic [$clog2(PWRUP_CYC+1)-1:0] pw_cnt_r;
  sdmc_state_t state_r;

  // ******************************************************
  // Write decode
  // ******************************************************
  logic wr_mode;
  logic wr_aux;
  logic wr_processor_power_control;
  logic p_rise;
  logic a_rise;
  logic both_rst;
  logic aux_only;
  logic cal_req;
  logic cal_done;
  logic resume;

  always_comb
  begin
    wr_mode  = sfr_wr && sfr_addr == SDMC_MODE_ADDR;
    wr_aux   = sfr_wr && (sfr_addr == SDMC_AUX1_ADDR || sfr_addr == SDMC_AUX2_ADDR);
    wr_processor_power_control  = sfr_wr && sfr_addr == SDMC_PROCESSOR_POWER_CONTROL_ADDR;
    p_rise   = wr_mode && sfr_wdata[SDMC_P_EN_BIT] && !mode_r[SDMC_P_EN_BIT];
    a_rise   = wr_mode && sfr_wdata[SDMC_A_EN_BIT] && !mode_r[SDMC_A_EN_BIT];
    resume   = wr_processor_power_control && pd_r && !sfr_wdata[SDMC_PD_BIT];
    // Any mode write counts, even unchanged contents
    both_rst = wr_mode || (wr_aux && mode_r[SDMC_P_EN_BIT]) || p_rise;
    aux_only = !both_rst && (wr_aux || a_rise);
    cal_req  = wr_mode && sfr_wdata[2:0] >= SDMC_MD_CAL_LO;
    cal_done = state_r == SDMC_CAL && prim_out_tick && cal_cnt_r == 3'h1;
  end

  // ******************************************************
  // Configuration registers
  // ******************************************************
  // Unimplemented bits masked at write so they read as zero
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pcfg_r <= SDMC_PCFG_RST;
      exc_r  <= SDMC_EXC_RST;
      aux1_r <= 8'h00;
      aux2_r <= 8'h00;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == SDMC_PCFG_ADDR)
        pcfg_r <= sfr_wdata & SDMC_PCFG_MASK;
      if (sfr_addr == SDMC_EXC_ADDR)
        exc_r <= sfr_wdata & SDMC_EXC_MASK;
      if (sfr_addr == SDMC_AUX1_ADDR)
        aux1_r <= sfr_wdata;
      if (sfr_addr == SDMC_AUX2_ADDR)
        aux2_r <= sfr_wdata;
    end
  end

  // Mode register survives power-down; calibration end clears only mode bits 2:0
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      mode_r <= SDMC_MODE_RST;
    else if (wr_mode)
      mode_r <= sfr_wdata;
    else if (cal_done)
      mode_r[2:0] <= SDMC_MD_PDOWN;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      pd_r <= 1'b0;
    else if (wr_processor_power_control)
      pd_r <= sfr_wdata[SDMC_PD_BIT];
  end

  // ******************************************************
  // Sequencer
  // ******************************************************
  // Power-up wait guards both first start and resume from power-down
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r  <= SDMC_IDLE;
      pw_cnt_r <= '0;
      cal_cnt_r <= 3'h0;
      cal_aux_r <= 1'b0;
    end
    else if (pd_r)
      state_r <= SDMC_IDLE;
    else
    begin
      case (state_r)
        SDMC_IDLE:
        begin
          if (both_rst || resume || (mode_r[2:0] != SDMC_MD_PDOWN))
          begin
            state_r  <= SDMC_PWUP;
            pw_cnt_r <= '0;
          end
        end
        SDMC_PWUP:
        begin
          if (32'(pw_cnt_r) >= PWRUP_CYC - 1)
          begin
            state_r <= (mode_r[2:0] >= SDMC_MD_CAL_LO) ? SDMC_CAL : SDMC_RUN;
            cal_cnt_r <= mode_r[SDMC_CHOP_BIT] ? SDMC_CAL_NOCHOP : SDMC_CAL_CHOP;
            cal_aux_r <= mode_r[SDMC_A_EN_BIT] && !mode_r[SDMC_P_EN_BIT];
          end
          else
            pw_cnt_r <= pw_cnt_r + 1'b1;
        end
        SDMC_RUN:
        begin
          if (cal_req)
          begin
            state_r <= SDMC_CAL;
            cal_cnt_r <= sfr_wdata[SDMC_CHOP_BIT] ? SDMC_CAL_NOCHOP : SDMC_CAL_CHOP;
            cal_aux_r <= sfr_wdata[SDMC_A_EN_BIT] && !sfr_wdata[SDMC_P_EN_BIT];
          end
          else if (mode_r[2:0] == SDMC_MD_PDOWN)
            state_r <= SDMC_IDLE;
        end
        SDMC_CAL:
        begin
          if (cal_done)
            state_r <= SDMC_IDLE;
          else if (prim_out_tick)
            cal_cnt_r <= cal_cnt_r - 3'h1;
        end
        default:
          state_r <= SDMC_IDLE;
      endcase
    end
  end

  // ******************************************************
  // Status flags
  // ******************************************************
  // Set wins over the clear from a new calibration request
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      primary_ready_flag_r <= 1'b0;
      aux_ready_flag_r <= 1'b0;
      aux_error_flag_r <= 1'b0;
    end
    else if (cal_done)
    begin
      primary_ready_flag_r <= !cal_aux_r;
      aux_ready_flag_r <= cal_aux_r;
      aux_error_flag_r <= cal_aux_r && aux1_r[SDMC_TSENS_BIT];
    end
    else if (cal_req)
    begin
      // A result landing in the same cycle still sets its flag
      primary_ready_flag_r <= state_r == SDMC_RUN && prim_out_tick;
      aux_ready_flag_r <= state_r == SDMC_RUN && aux_out_tick;
      aux_error_flag_r <= 1'b0;
    end
    else
    begin
      if (state_r == SDMC_RUN && prim_out_tick)
        primary_ready_flag_r <= 1'b1;
      if (state_r == SDMC_RUN && aux_out_tick)
        aux_ready_flag_r <= 1'b1;
    end
  end

  // ******************************************************
  // Auxiliary alignment
  // ******************************************************
  // Aux waits for primary outputs instead of running out of phase
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      aux_wait_r <= 1'b0;
      aux_cnt_r  <= 2'h0;
    end
    else if (aux_only && state_r == SDMC_RUN)
    begin
      aux_wait_r <= 1'b1;
      aux_cnt_r  <= SDMC_AUX_SYNC;
    end
    else if (aux_wait_r && prim_out_tick)
    begin
      aux_cnt_r <= aux_cnt_r - 2'h1;
      if (aux_cnt_r == 2'h1)
        aux_wait_r <= 1'b0;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      prim_reset   <= 1'b0;
      aux_reset    <= 1'b0;
      aux_start    <= 1'b0;
      cal_write    <= 1'b0;
      front_cfg    <= '0;
      exc_cfg      <= '0;
      conv_powered <= 1'b0;
      sfr_rdata    <= 8'h00;
    end
    else
    begin
      prim_reset <= both_rst;
      aux_reset  <= both_rst || aux_only;
      // Without a running primary there is nothing to align to
      aux_start  <= (aux_only && state_r != SDMC_RUN)
                  || (aux_wait_r && prim_out_tick && aux_cnt_r == 2'h1);
      cal_write  <= cal_done && !(cal_aux_r && aux1_r[SDMC_TSENS_BIT]);
      front_cfg.buf_sel   <= pcfg_r[7:6];
      front_cfg.unipolar  <= pcfg_r[5];
      front_cfg.range_sel <= pcfg_r[2:0];
      exc_cfg.src_a_en    <= exc_r[0];
      exc_cfg.src_b_en    <= exc_r[1];
      exc_cfg.src_a_analog_input_eight  <= exc_r[2];
      exc_cfg.src_b_analog_input_seven  <= exc_r[3];
      exc_cfg.burnout_en  <= exc_r[6];
      conv_powered <= state_r == SDMC_RUN || state_r == SDMC_CAL;
      case (sfr_addr)
        SDMC_PCFG_ADDR: sfr_rdata <= pcfg_r;
        SDMC_EXC_ADDR:  sfr_rdata <= exc_r;
        SDMC_MODE_ADDR: sfr_rdata <= mode_r;
        SDMC_AUX1_ADDR: sfr_rdata <= aux1_r;
        SDMC_AUX2_ADDR: sfr_rdata <= aux2_r;
        SDMC_STAT_ADDR: sfr_rdata <= {primary_ready_flag_r, aux_ready_flag_r, 1'b0, aux_error_flag_r, 4'h0};
        SDMC_PROCESSOR_POWER_CONTROL_ADDR: sfr_rdata <= {6'h00, pd_r, 1'b0};
        default:        sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  property p_mode_rst;
    @(posedge clk_sys) disable iff (reset)
    wr_mode |=> prim_reset && aux_reset;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode write no reset");

  property p_same_rst;
    @(posedge clk_sys) disable iff (reset)
    (wr_mode && sfr_wdata[2:0] == mode_r[2:0]) |=> prim_reset;
  endproperty
  a_same_rst: assert property (p_same_rst) else $error("same mode no reset");

  property p_aux_prim;
    @(posedge clk_sys) disable iff (reset)
    (wr_aux && mode_r[SDMC_P_EN_BIT]) |=> prim_reset && aux_reset;
  endproperty
  a_aux_prim: assert property (p_aux_prim) else $error("aux write missed both");

  property p_aux_only;
    @(posedge clk_sys) disable iff (reset)
    aux_only |=> aux_reset && !prim_reset;
  endproperty
  a_aux_only: assert property (p_aux_only) else $error("aux only wrong");

  property p_aux_imm;
    @(posedge clk_sys) disable iff (reset)
    (aux_only && state_r != SDMC_RUN) |=> aux_start;
  endproperty
  a_aux_imm: assert property (p_aux_imm) else $error("aux not immediate");

  property p_cal_md;
    @(posedge clk_sys) disable iff (reset)
    (cal_done && !wr_mode) |=> mode_r[2:0] == SDMC_MD_PDOWN && state_r == SDMC_IDLE;
  endproperty
  a_cal_md: assert property (p_cal_md) else $error("cal end mode");

  property p_cal_err;
    @(posedge clk_sys) disable iff (reset)
    (cal_done && cal_aux_r && aux1_r[SDMC_TSENS_BIT]) |=> aux_error_flag_r && aux_ready_flag_r && !cal_write;
  endproperty
  a_cal_err: assert property (p_cal_err) else $error("temp cal flags");

  property p_exc_norst;
    @(posedge clk_sys) disable iff (reset)
    (sfr_wr && sfr_addr == SDMC_EXC_ADDR) |=> !prim_reset && !aux_reset;
  endproperty
  a_exc_norst: assert property (p_exc_norst) else $error("exc write reset");

  c_cal:  cover property (@(posedge clk_sys) disable iff (reset) cal_done);
  c_sync: cover property (@(posedge clk_sys) disable iff (reset) aux_wait_r ##1 !aux_wait_r);
  c_pd:   cover property (@(posedge clk_sys) disable iff (reset) resume);

endmodule

// File: tb/sdmc_afe_model.sv
`timescale 1ns/1ps

// ****************************************
// Analog front end stand-in
// ****************************************
module sdmc_afe_model #(
  parameter int PERIOD = 8
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic powered,
  input  wire logic prim_reset,
  output logic      prim_out_tick,
  output logic      aux_out_tick
);
  int cnt;

  // Output phase; no results until the converter is powered up
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset || !powered || prim_reset)
      cnt <= 0;
    else
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  end

  // One-cycle strobes; aux trails the primary cycle by one clock
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      prim_out_tick <= 1'b0;
      aux_out_tick  <= 1'b0;
    end
    else
    begin
      prim_out_tick <= powered && (cnt == PERIOD - 1);
      aux_out_tick  <= prim_out_tick;
    end
  end
endmodule

// File: tb/test_sigma_delta_adc_mode_control.sv
`timescale 1ns/1ps

module test_sigma_delta_adc_mode_control;
  import sdmc_pkg::*;

  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        prim_out_tick, aux_out_tick, prim_reset, aux_reset;
  logic        aux_start, cal_write, conv_powered;
  logic [7:0]  sfr_rdata;
  sdmc_front_t front_cfg;
  sdmc_exc_t   exc_cfg;
  int          num_errors = 0;
  int          num_checks = 0;
  int          n_prst, n_arst, n_ast, n_cal, n_tick;

  // ****************************************
  // Clock, design and front end
  // ****************************************
  always #2.5 clk_sys = ~clk_sys;

  sdmc_ctrl #(.PWRUP_CYC(10)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .prim_out_tick(prim_out_tick), .aux_out_tick(aux_out_tick),
    .sfr_rdata(sfr_rdata), .prim_reset(prim_reset), .aux_reset(aux_reset),
    .aux_start(aux_start), .cal_write(cal_write), .front_cfg(front_cfg),
    .exc_cfg(exc_cfg), .conv_powered(conv_powered));

  sdmc_afe_model afe_u (
    .clk_sys(clk_sys), .reset(reset), .powered(conv_powered), .prim_reset(prim_reset),
    .prim_out_tick(prim_out_tick), .aux_out_tick(aux_out_tick));

  // Pulse counters; pulses last one cycle, so count rather than poll
  always @(posedge clk_sys)
  begin
    n_prst += int'(prim_reset === 1'b1);
    n_arst += int'(aux_reset === 1'b1);
    n_ast  += int'(aux_start === 1'b1);
    n_cal  += int'(cal_write === 1'b1);
    n_tick += int'(prim_out_tick === 1'b1);
  end

  // ****************************************
  // Access and check tasks
  // ****************************************
  task automatic print_verdict(input bit hung);
    if (hung)
      num_errors++;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Strobe for one edge, then an idle edge so strobes never abut
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    sfr_addr = a;
    cyc(1);
    cmp(sfr_rdata & m, exp);
  endtask

  task automatic clr();
    n_prst = 0;
    n_arst = 0;
    n_ast = 0;
    n_cal = 0;
    n_tick = 0;
  endtask

  task automatic wait_pow(input logic v);
    for (int i = 0; i < 200 && conv_powered !== v; i++)
      cyc(1);
    if (conv_powered !== v)
      print_verdict(1'b1);
  endtask

  task automatic wait_ticks(input int n);
    for (int i = 0; i < 400 && n_tick < n; i++)
      cyc(1);
    if (n_tick < n)
      print_verdict(1'b1);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] d;
    logic [7:0] cm;
    int         nt;
    clr();
    cyc(10);
    reset = 1'b0;
    cyc(1);
    rd(SDMC_PCFG_ADDR, 8'h07);
    rd(SDMC_EXC_ADDR, 8'h00);
    rd(8'hD0, 8'h00);
    // Every field code, with unimplemented bits written as ones
    for (int i = 0; i < 16; i++)
    begin
      clr();
      d = {i[1:0], i[2], 2'b11, i[2:0]};
      wr(SDMC_PCFG_ADDR, d);
      rd(SDMC_PCFG_ADDR, d & 8'hE7);
      cmp(8'(front_cfg), {2'b00, i[1:0], i[2], i[2:0]});
      d = {1'b1, i[0] ^ i[3], 2'b11, i[3:0]};
      wr(SDMC_EXC_ADDR, d);
      rd(SDMC_EXC_ADDR, d & 8'h4F);
      cmp(8'(exc_cfg), {3'b000, d[6], d[0], d[1], d[2], d[3]});
      cmp(8'(n_prst + n_arst), 8'h00);
    end
    // Same mode written twice still resets both
    for (int i = 0; i < 2; i++)
    begin
      clr();
      wr(SDMC_MODE_ADDR, 8'h23);
      cmp(8'(n_prst * 16 + n_arst), 8'h11);
    end
    wait_pow(1'b1);
    clr();
    wr(SDMC_AUX1_ADDR, 8'h00);
    wr(SDMC_AUX2_ADDR, 8'h00);
    cmp(8'(n_prst * 16 + n_arst), 8'h22);
    wr(SDMC_PROCESSOR_POWER_CONTROL_ADDR, 8'h02);
    wait_pow(1'b0);
    rd(SDMC_MODE_ADDR, 8'h23);
    wr(SDMC_PROCESSOR_POWER_CONTROL_ADDR, 8'h00);
    wait_pow(1'b1);
    // Aux-only reset while running waits for the primary cycle
    wr(SDMC_MODE_ADDR, 8'h13);
    wait_pow(1'b1);
    clr();
    wr(SDMC_AUX1_ADDR, 8'h00);
    cmp(8'(n_prst * 16 + n_arst), 8'h01);
    wait_ticks(2);
    cmp(8'(n_ast), 8'h00);
    wait_ticks(3);
    cyc(2);
    cmp(8'(n_ast), 8'h01);
    wr(SDMC_MODE_ADDR, 8'h10);
    wait_pow(1'b0);
    clr();
    wr(SDMC_AUX1_ADDR, 8'h00);
    cyc(1);
    cmp(8'(n_arst * 16 + n_ast), 8'h11);
    // Chop on, chop off, then aux calibration with temp sensor
    for (int i = 0; i < 3; i++)
    begin
      // Mode byte and primary outputs per calibration for this pass
      cm = (i == 0) ? 8'h04 : (i == 1) ? 8'h0C : 8'h14;
      nt = (i == 1) ? 4 : 2;
      if (i == 2)
        wr(SDMC_AUX1_ADDR, 8'h80);
      clr();
      wr(SDMC_MODE_ADDR, cm);
      rd(SDMC_STAT_ADDR, 8'h00, 8'hC0);
      wait_ticks(nt - 1);
      cmp(8'(n_cal), 8'h00);
      wait_ticks(nt);
      cyc(3);
      cmp(8'(n_cal), (i == 2) ? 8'h00 : 8'h01);
      rd(SDMC_MODE_ADDR, cm & 8'hF8);
      rd(SDMC_STAT_ADDR, (i == 2) ? 8'h50 : 8'h80, 8'hD0);
    end
    print_verdict(1'b0);
  end
endmodule
